// file: dsso_defs.svh
// Constants for the dual-axis safe shut-off logic
`ifndef DSSO_DEFS_SVH
`define DSSO_DEFS_SVH

`define DSSO_CLOCK_HZ 100000000
`define DSSO_TICK_MS 1
`define DSSO_TICK_CYCLES (`DSSO_CLOCK_HZ / 1000 * `DSSO_TICK_MS)
`define DSSO_TICK_W 17

`define DSSO_DELAY_W 15
`define DSSO_SEL_W 3
`define DSSO_SEL_0S0 3'h0
`define DSSO_SEL_1S4 3'h1
`define DSSO_SEL_2S8 3'h2
`define DSSO_SEL_5S6 3'h3
`define DSSO_SEL_9S8 3'h4
`define DSSO_SEL_30S8 3'h5

// Delays in milliseconds, counted in 1 ms ticks
`define DSSO_DLY_NONE_MS 15'h0000
`define DSSO_DLY_1S4_MS 15'h0578
`define DSSO_DLY_2S8_MS 15'h0af0
`define DSSO_DLY_5S6_MS 15'h15e0
`define DSSO_DLY_9S8_MS 15'h2648
`define DSSO_DLY_30S8_MS 15'h7850

// Time a feedback mismatch may last before it counts as a fault
`define DSSO_FEEDBACK_MS 8'h64
`define DSSO_FEEDBACK_W 8

`define DSSO_IN_SW1 0
`define DSSO_IN_SW2 1
`define DSSO_IN_RST 2
`define DSSO_IN_FB 3
`define DSSO_IN_W 4

`endif

// file: dsso_pkg.sv
// Types and delay decoding for the dual-axis safe shut-off logic
`include "dsso_defs.svh"

package dsso_pkg;

   typedef enum logic [1:0] {
      dsso_shutoff = 2'b00,
      dsso_released = 2'b01,
      dsso_stopping = 2'b10
   } dsso_state_type;

   typedef logic [`DSSO_DELAY_W-1:0] dsso_ticks_type;
   typedef logic [`DSSO_SEL_W-1:0] dsso_sel_type;

   // Unknown codes, and the mid step where it is absent, fall back to no delay
   function automatic dsso_ticks_type dsso_delay_ticks(input dsso_sel_type sel,
                                                       input logic allow_mid);
      dsso_ticks_type ticks;
      ticks = `DSSO_DLY_NONE_MS;
      case (sel)
         `DSSO_SEL_1S4: ticks = `DSSO_DLY_1S4_MS;
         `DSSO_SEL_2S8: ticks = `DSSO_DLY_2S8_MS;
         `DSSO_SEL_5S6: ticks = allow_mid ? `DSSO_DLY_5S6_MS : `DSSO_DLY_NONE_MS;
         `DSSO_SEL_9S8: ticks = `DSSO_DLY_9S8_MS;
         `DSSO_SEL_30S8: ticks = `DSSO_DLY_30S8_MS;
         default: ticks = `DSSO_DLY_NONE_MS;
      endcase
      return ticks;
   endfunction

endpackage

// file: dsso_timer_if.sv
// Link between an axis controller and its shut-off delay timer
`timescale 1ns/1ps
`include "dsso_defs.svh"

interface dsso_timer_if;
   logic load;
   logic [`DSSO_DELAY_W-1:0] load_ticks;
   logic tick;
   logic expired;

   modport ctrl (
      output load,
      output load_ticks,
      output tick,
      input expired
   );

   modport timer (
      input load,
      input load_ticks,
      input tick,
      output expired
   );
endinterface

// file: dsso_delay_timer.sv
// Millisecond countdown for the shut-off output delay
`timescale 1ns/1ps
`include "dsso_defs.svh"

module dsso_delay_timer (
   input wire logic clock,
   input wire logic reset,
   dsso_timer_if.timer port
);
   import dsso_pkg::*;

   dsso_ticks_type count;
   wire counting = (count != `DSSO_DLY_NONE_MS);

   // A load in the same cycle hides the old zero so the caller never sees a stale expiry
   assign port.expired = ~counting & ~port.load;

   always_ff @(posedge clock) begin
      if (reset) begin
         count <= `DSSO_DLY_NONE_MS;
      end else if (port.load) begin
         count <= port.load_ticks;
      end else if (port.tick && counting) begin
         count <= count - 1'b1;
      end
   end
endmodule

// file: dsso_safe_shutoff.sv
// Two-axis safe shut-off controller: per-axis release, delayed shut-off and feedback check
//
// Function
// - Both shut-off outputs of an axis are off in the shut-off state and on when released.
// - The two shut-off outputs of an axis always carry the same value.
// - The two diagnostic outputs of an axis follow the shut-off outputs.
// - The two diagnostic outputs of an axis always carry the same value.
// - An open switch input demands shut-off and a closed one permits driving.
// - An axis leaves shut-off only on a closed-to-open edge of its reset input.
// - The feedback input reads the driver state: open is shut off, closed is driving.
// - The two axes run as independent channels with no shared state besides the millisecond tick.
// - The shut-off delay is selectable per axis, and axis B lacks the 5.6 s step.
// - With no delay selected the outputs turn off within 10 ms of a switch opening.
`timescale 1ns/1ps
`include "dsso_defs.svh"

module dsso_safe_shutoff #(
   parameter int TICK_CYCLES = `DSSO_TICK_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [1:0] switch_in_first,
   input wire logic [1:0] switch_in_second,
   input wire logic [1:0] release_reset_in,
   input wire logic [1:0] drive_state_feedback,
   input wire dsso_pkg::dsso_sel_type delay_select_a,
   input wire dsso_pkg::dsso_sel_type delay_select_b,
   output logic [1:0] shutoff_out_first,
   output logic [1:0] shutoff_out_second,
   output logic [1:0] diag_out_first,
   output logic [1:0] diag_out_second,
   output logic [1:0] axis_shutoff,
   output logic [1:0] driver_shutoff,
   output logic [1:0] feedback_fault
);
   import dsso_pkg::*;

   // Shared millisecond enable; only a time base, no axis state passes through it
   logic [`DSSO_TICK_W-1:0] tick_count;
   logic tick;
   wire tick_wrap = (tick_count == `DSSO_TICK_W'(TICK_CYCLES - 1));
   // Restarts with reset, so both axes see their first tick one period later
   wire [`DSSO_TICK_W-1:0] next_tick_count = tick_wrap ? '0 : tick_count + 1'b1;

   always_ff @(posedge clock) begin
      if (reset) begin
         tick_count <= '0;
         tick <= 1'b0;
      end else begin
         tick_count <= next_tick_count;
         tick <= tick_wrap;
      end
   end

   // Delay selectors come from switches outside this clock domain
   dsso_sel_type sel_meta [2];
   dsso_sel_type sel_sync [2];

   always_ff @(posedge clock) begin
      if (reset) begin
         sel_meta[0] <= `DSSO_SEL_0S0;
         sel_meta[1] <= `DSSO_SEL_0S0;
         sel_sync[0] <= `DSSO_SEL_0S0;
         sel_sync[1] <= `DSSO_SEL_0S0;
      end else begin
         sel_meta[0] <= delay_select_a;
         sel_meta[1] <= delay_select_b;
         sel_sync[0] <= sel_meta[0];
         sel_sync[1] <= sel_meta[1];
      end
   end

   for (genvar axis = 0; axis < 2; axis++) begin : g_axis
      // Each axis owns its inputs, timer and state
      dsso_timer_if tmr ();

      dsso_delay_timer u_timer (
         .clock(clock),
         .reset(reset),
         .port(tmr.timer)
      );

      logic [`DSSO_IN_W-1:0] pin_meta;
      logic [`DSSO_IN_W-1:0] pin;
      logic reset_prev;
      dsso_state_type state;
      dsso_state_type next_state;
      logic drive_on;
      logic fault;
      logic [`DSSO_FEEDBACK_W-1:0] mismatch_ms;

      wire [`DSSO_IN_W-1:0] pin_raw = {drive_state_feedback[axis], release_reset_in[axis],
                                       switch_in_second[axis], switch_in_first[axis]};

      // A closed contact reads as one; driving needs both channels closed
      wire switches_closed = pin[`DSSO_IN_SW1] & pin[`DSSO_IN_SW2];
      wire shutoff_demand = ~switches_closed;
      wire reset_fall = reset_prev & ~pin[`DSSO_IN_RST];
      wire driver_driving = pin[`DSSO_IN_FB];
      // An edge that is refused here is consumed, not held for later
      wire release_ok = reset_fall & switches_closed & ~fault;
      // Axis B gets no mid step; the decoder folds that code to no delay
      wire dsso_ticks_type delay_ticks =
         dsso_delay_ticks(sel_sync[axis], axis == 0);
      wire no_delay = (delay_ticks == `DSSO_DLY_NONE_MS);
      wire next_drive_on = (next_state != dsso_shutoff);
      wire mismatch = (drive_on != driver_driving);
      wire mismatch_full = (mismatch_ms == `DSSO_FEEDBACK_MS);

      // The age saturates, so a long mismatch can never wrap back to zero
      wire mismatch_step = tick & ~mismatch_full;
      wire [`DSSO_FEEDBACK_W-1:0] next_mismatch_ms =
         ~mismatch ? '0 : (mismatch_step ? mismatch_ms + 1'b1 : mismatch_ms);
      wire fault_set = mismatch_full;
      // Clearing needs the driver to report shut off, so a stuck driver stays faulted
      wire fault_clear = (state == dsso_shutoff) & ~driver_driving & reset_fall;

      assign tmr.tick = tick;
      // The delay timer is loaded only when a timed shut-off was asked for
      wire stop_request = (state == dsso_released) & shutoff_demand;
      assign tmr.load = stop_request & ~no_delay;
      assign tmr.load_ticks = delay_ticks;

      always_comb begin
         next_state = state;
         unique case (state)
            dsso_shutoff: begin
               if (release_ok) begin
                  next_state = dsso_released;
               end
            end
            dsso_released: begin
               if (shutoff_demand) begin
                  next_state = no_delay ? dsso_shutoff : dsso_stopping;
               end
            end
            dsso_stopping: begin
               // Reclosing the switches does not cancel a shut-off already under way
               if (tmr.expired) begin
                  next_state = dsso_shutoff;
               end
            end
            default: begin
               next_state = dsso_shutoff;
            end
         endcase
      end

      // First stage feeds only the second
      always_ff @(posedge clock) begin
         if (reset) begin
            pin_meta <= '0;
            pin <= '0;
         end else begin
            pin_meta <= pin_raw;
            pin <= pin_meta;
         end
      end

      // Starts at open so that leaving reset can never look like a release edge
      always_ff @(posedge clock) begin
         if (reset) begin
            reset_prev <= 1'b0;
         end else begin
            reset_prev <= pin[`DSSO_IN_RST];
         end
      end

      // Outputs come from this flop rather than the decode, so they cannot glitch
      always_ff @(posedge clock) begin
         if (reset) begin
            state <= dsso_shutoff;
            drive_on <= 1'b0;
         end else begin
            state <= next_state;
            drive_on <= next_drive_on;
         end
      end

      // Mismatch age in ticks; agreement clears it at once
      always_ff @(posedge clock) begin
         if (reset) begin
            mismatch_ms <= '0;
         end else begin
            mismatch_ms <= next_mismatch_ms;
         end
      end

      // Sticky until a reset edge in shut-off; a faulted axis cannot be released.
      // A set in the same cycle as a clear wins, so a live fault is never lost.
      always_ff @(posedge clock) begin
         if (reset) begin
            fault <= 1'b0;
         end else if (fault_set) begin
            fault <= 1'b1;
         end else if (fault_clear) begin
            fault <= 1'b0;
         end
      end

      // One flop feeds every output pair so the channels cannot diverge
      assign shutoff_out_first[axis] = drive_on;
      assign shutoff_out_second[axis] = drive_on;
      assign diag_out_first[axis] = drive_on;
      assign diag_out_second[axis] = drive_on;
      assign axis_shutoff[axis] = ~drive_on;
      // Registered so the status carries no combinational path from the pins
      wire next_driver_shutoff = ~driver_driving;

      always_ff @(posedge clock) begin
         if (reset) begin
            driver_shutoff[axis] <= 1'b1;
            feedback_fault[axis] <= 1'b0;
         end else begin
            driver_shutoff[axis] <= next_driver_shutoff;
            feedback_fault[axis] <= fault;
         end
      end
   end
endmodule

// file: dsso_properties.sv
// Port-level assertions for the dual-axis safe shut-off logic
`timescale 1ns/1ps
module dsso_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic [1:0] switch_in_first,
   input wire logic [1:0] switch_in_second,
   input wire logic [1:0] release_reset_in,
   input wire logic [1:0] drive_state_feedback,
   input wire dsso_pkg::dsso_sel_type delay_select_a,
   input wire dsso_pkg::dsso_sel_type delay_select_b,
   input wire logic [1:0] shutoff_out_first,
   input wire logic [1:0] shutoff_out_second,
   input wire logic [1:0] diag_out_first,
   input wire logic [1:0] diag_out_second,
   input wire logic [1:0] axis_shutoff,
   input wire logic [1:0] driver_shutoff,
   input wire logic [1:0] feedback_fault
);
   import dsso_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_outputs_paired: assert property (shutoff_out_first == shutoff_out_second)
      else $error("shut-off pair differs");
   a_diag_paired: assert property (diag_out_first == diag_out_second)
      else $error("diag pair differs");
   a_diag_mirrors: assert property (diag_out_first == shutoff_out_first)
      else $error("diag differs from shut-off");
   a_state_inverse: assert property (axis_shutoff == ~shutoff_out_first)
      else $error("state flag not inverse");
   a_reset_values: assert property (disable iff (1'b0) reset |=>
      shutoff_out_first == 2'h0 && axis_shutoff == 2'h3 && feedback_fault == 2'h0)
      else $error("bad values after reset");
   a_release_edge: assert property ($rose(shutoff_out_first[0]) |->
      !$past(release_reset_in[0], 3) && $past(release_reset_in[0], 4))
      else $error("release without reset edge");
   a_release_closed: assert property ($rose(shutoff_out_first[0]) |->
      $past(switch_in_first[0] & switch_in_second[0], 3))
      else $error("axis A released with switch open");
   a_release_axis_b: assert property ($rose(shutoff_out_first[1]) |->
      $past(switch_in_first[1] & switch_in_second[1], 3))
      else $error("axis B released with switch open");
   a_zero_delay: assert property (delay_select_a == 3'h0 && $fell(switch_in_first[0])
      |-> ##[1:5] !shutoff_out_first[0])
      else $error("no prompt shut-off");
   a_feedback_read: assert property (drive_state_feedback[0] [*5] |->
      !driver_shutoff[0])
      else $error("feedback not read");
endmodule

// file: dsso_drive_model.sv
// Servo driver model: reports driving while both shut-off channels conduct
`timescale 1ns/1ps
module dsso_drive_model #(
   parameter int LAG = 4
) (
   input wire logic clock,
   input wire logic [1:0] on_first,
   input wire logic [1:0] on_second,
   input wire logic [1:0] stuck,
   output logic [1:0] feedback
);
   logic [1:0] pipe [LAG] = '{default: 2'h0};
   // Stuck models a driver whose feedback contact never closes
   always_ff @(posedge clock) begin
      pipe[0] <= on_first & on_second & ~stuck;
      for (int i = 1; i < LAG; i++) begin
         pipe[i] <= pipe[i-1];
      end
   end
   assign feedback = pipe[LAG-1];
endmodule

// file: tb_dual_axis_safe_shutoff_logic.sv
// Self-checking bench for the dual-axis safe shut-off logic
`timescale 1ns/1ps
module tb_dual_axis_safe_shutoff_logic;
   import dsso_pkg::*;
   logic clock = 0;
   logic reset = 1;
   logic [1:0] sw1 = 2'h3, sw2 = 2'h3, rr = 2'h0, stuck = 2'h0, fb;
   logic [1:0] so1, so2, do1, do2, ax, drv, flt;
   dsso_sel_type sel_a = 3'h0;
   dsso_sel_type sel_b = 3'h3;
   int errors = 0, total_checks = 0, cycles = 0;
   always #5 clock = ~clock;
   dsso_safe_shutoff #(.TICK_CYCLES(10)) i_dut (.clock(clock), .reset(reset),
      .switch_in_first(sw1), .switch_in_second(sw2), .release_reset_in(rr),
      .drive_state_feedback(fb), .delay_select_a(sel_a), .delay_select_b(sel_b),
      .shutoff_out_first(so1), .shutoff_out_second(so2), .diag_out_first(do1),
      .diag_out_second(do2), .axis_shutoff(ax), .driver_shutoff(drv),
      .feedback_fault(flt));
   dsso_drive_model i_drv (.clock(clock), .on_first(so1), .on_second(so2),
      .stuck(stuck), .feedback(fb));
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic outs(input logic [1:0] e);
      chk(so1, e);
      chk(so2, e);
      chk(do1, e);
      chk(do2, e);
      chk(ax, ~e);
   endtask
   // Reset input held closed long enough to fill the synchronisers
   task automatic rel(input int a);
      rr[a] = 1'b1;
      step(6);
      rr[a] = 1'b0;
      step(6);
   endtask
   task automatic t_reset;
      outs(2'h0);
      chk(drv, 2'h3);
      chk(flt, 2'h0);
      $display("test reset done");
   endtask
   task automatic t_release;
      rel(0);
      outs(2'h1);
      sw2[1] = 1'b0;
      rel(1);
      outs(2'h1);
      sw2[1] = 1'b1;
      step(8);
      outs(2'h1);
      rel(1);
      outs(2'h3);
      $display("test release done");
   endtask
   task automatic t_zero;
      sw1[1] = 1'b0;
      sw2[1] = 1'b0;
      step(5);
      outs(2'h1);
      sw1[1] = 1'b1;
      sw2[1] = 1'b1;
      step(8);
      outs(2'h1);
      chk(drv, 2'h2);
      sw1[0] = 1'b0;
      sw2[0] = 1'b0;
      step(5);
      outs(2'h0);
      $display("test zero delay done");
   endtask
   task automatic t_delay;
      sw1[0] = 1'b1;
      sw2[0] = 1'b1;
      sel_a = 3'h1;
      rel(0);
      sw1[0] = 1'b0;
      sw2[0] = 1'b0;
      step(13980);
      outs(2'h1);
      step(40);
      outs(2'h0);
      $display("test delay done");
   endtask
   task automatic t_fault;
      sw1[0] = 1'b1;
      sw2[0] = 1'b1;
      stuck[0] = 1'b1;
      rel(0);
      outs(2'h1);
      chk(drv, 2'h3);
      step(1100);
      chk(flt, 2'h1);
      sel_a = 3'h0;
      step(4);
      sw1[0] = 1'b0;
      sw2[0] = 1'b0;
      step(5);
      outs(2'h0);
      sw1[0] = 1'b1;
      sw2[0] = 1'b1;
      rel(0);
      outs(2'h0);
      chk(flt, 2'h0);
      rel(0);
      outs(2'h1);
      $display("test fault done");
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         tally_and_finish;
      end
   end
   initial begin
      step(20);
      reset = 1'b0;
      step(2);
      t_reset;
      t_release;
      t_zero;
      t_delay;
      t_fault;
      tally_and_finish;
   end
endmodule
bind dsso_safe_shutoff dsso_checker i_chk (.clock, .reset, .switch_in_first,
   .switch_in_second, .release_reset_in, .drive_state_feedback, .delay_select_a,
   .delay_select_b, .shutoff_out_first, .shutoff_out_second, .diag_out_first,
   .diag_out_second, .axis_shutoff, .driver_shutoff, .feedback_fault);
